/* logic/sfpf_pkg.sv */
// Purpose : shared types and constants of the serial flash pin front end
// Assumes : sampled by a 10 MHz system clock, link clock far slower
// Notes   : pin groups travel as packed structs
package sfpf_pkg;

    // ************************************************************
    // transfer width and link state
    // ************************************************************
    typedef enum logic [1:0] {
        SFPF_W1 = 2'b00,
        SFPF_W2 = 2'b01,
        SFPF_W4 = 2'b10
    } sfpf_width_e;

    typedef enum logic [1:0] {
        LS_OFF    = 2'b00,
        LS_IDLE   = 2'b01,
        LS_ACTIVE = 2'b10,
        LS_PAUSE  = 2'b11
    } sfpf_link_e;

    // ************************************************************
    // carriers
    // ************************************************************
    typedef struct packed {
        logic       status_write_disable;
        logic       quad_io_enable;
        logic [3:0] block_protect;
    } sfpf_stat_s;

    typedef struct packed {
        logic [3:0] data_line_in;
        logic       chip_select_n;
        logic       sck;
    } sfpf_pin_in_s;

    typedef struct packed {
        logic [3:0] data_line_out;
        logic [3:0] data_line_oe;
    } sfpf_pin_out_s;

    // ************************************************************
    // constants
    // ************************************************************
    localparam int         SFPF_SYNC_W    = 6;
    localparam int         SFPF_POS_SCK   = 0;
    localparam int         SFPF_POS_CS    = 1;
    localparam int         SFPF_POS_DL    = 2;
    // select preloads low: only a seen high level arms the first frame
    localparam logic [5:0] SFPF_SYNC_INIT = 6'h30;
    localparam logic [3:0] SFPF_BYTE_BITS = 4'h8;
    localparam logic [3:0] SFPF_LANES_1   = 4'h1;
    localparam logic [3:0] SFPF_LANES_2   = 4'h2;
    localparam logic [3:0] SFPF_LANES_4   = 4'h4;
    localparam logic [3:0] SFPF_OE_1      = 4'h2;
    localparam logic [3:0] SFPF_OE_2      = 4'h3;
    localparam logic [3:0] SFPF_OE_4      = 4'hF;
    localparam sfpf_stat_s SFPF_STAT_RST  = 6'h00;

endpackage : sfpf_pkg

/* logic/sfpf_sync.sv */
// Purpose : three-stage synchroniser with agreement filter
// Assumes : inputs asynchronous to clk_sys
// Notes   : a change counts once stages two and three agree
`timescale 1ns/10ps
module sfpf_sync #(
    parameter int           W    = 6,
    parameter logic [W-1:0] INIT = '0
) (
    input  wire logic         clk_sys,
    input  wire logic         rstn,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] lvl,
    output logic      [W-1:0] rise,
    output logic      [W-1:0] fall
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] lvl;
    } sfpf_sync_s;

    sfpf_sync_s   st;
    sfpf_sync_s   next_st;
    logic [W-1:0] agree;

    // ************************************************************
    // filter
    // ************************************************************
    always_comb begin
        agree       = ~(st.s2 ^ st.s3);
        next_st.s1  = din;
        next_st.s2  = st.s1;
        next_st.s3  = st.s2;
        next_st.lvl = (agree & st.s3) | (~agree & st.lvl);
        rise        = agree & st.s3 & ~st.lvl;
        fall        = agree & ~st.s3 & st.lvl;
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            st <= {INIT, INIT, INIT, INIT};
        end else begin
            st <= next_st;
        end
    end

    assign lvl = st.lvl;

endmodule : sfpf_sync

/* logic/sfpf_front.sv */
// Purpose : pin front end of a serial flash host interface
// Assumes : sck at most clk_sys/8; command logic steers width and drive
// Notes   : edges of sck are found by oversampling on clk_sys
//
// Function
// - chip select high: deselected, every output pin high impedance.
// - while deselected the device sits in low-power standby.
// - chip select low: selected, leaves standby, accepts transfers.
// - after power-up a select high-to-low edge precedes any instruction.
// - input bits presented with chip select high are ignored.
// - single line: bits sampled from serial_in on rising sck.
// - single line: serial_out changes on falling sck.
// - dual/quad: lines 0 and 1 bidirectional, in on rise, out on fall.
// - quad: write-protect and pause pins become data lines 2 and 3.
// - disable bit set, write-protect low: protection bit writes rejected.
// - disable bit clear: status writes allowed at any write-protect level.
// - data line 3 is pause or reset input by select bit, pause default.
// - only clock modes 0 and 3, sampling on rising edge.
// - quad enable set disables the write-protect function.
// - pause low while selected: output high impedance, sequence frozen.
`timescale 1ns/10ps
module sfpf_front
    import sfpf_pkg::*;
(
    input  wire logic                    clk_sys,
    input  wire logic                    rstn,
    input  wire sfpf_pkg::sfpf_pin_in_s  pin_in,
    output sfpf_pkg::sfpf_pin_out_s      pin_out,
    input  wire sfpf_pkg::sfpf_width_e   xfer_width,
    input  wire logic                    drive_en,
    input  wire logic [7:0]              tx_byte,
    output logic                         tx_taken,
    output logic      [7:0]              rx_byte,
    output logic                         rx_valid,
    input  wire logic                    sr_wr,
    input  wire sfpf_pkg::sfpf_stat_s    sr_wdata,
    output sfpf_pkg::sfpf_stat_s         sr_bits,
    output logic                         sr_reject,
    input  wire logic                    pause_or_reset_select,
    output sfpf_pkg::sfpf_link_e         link_state,
    output logic                         standby,
    output logic                         paused,
    output logic                         hw_reset
);
    import sfpf_pkg::*;

    typedef struct packed {
        sfpf_link_e ls;
        logic [7:0] rx_sh;
        logic [3:0] rx_cnt;
        logic [7:0] rx_byte;
        logic       rx_valid;
        logic [7:0] tx_sh;
        logic [3:0] tx_cnt;
        logic       tx_taken;
        logic [3:0] dout;
        logic [3:0] doe;
        sfpf_stat_s stat;
        logic       sr_reject;
        logic       hw_reset;
    } sfpf_front_s;

    localparam sfpf_front_s ST_RST = '{ls: LS_OFF, stat: SFPF_STAT_RST,
                                       default: '0};

    sfpf_front_s             st;
    sfpf_front_s             next_st;
    logic [SFPF_SYNC_W-1:0]  s_lvl;
    logic [SFPF_SYNC_W-1:0]  s_rise;
    logic [SFPF_SYNC_W-1:0]  s_fall;
    logic                    cs_n;
    logic                    sck_rise;
    logic                    sck_fall;
    logic [3:0]              dl;
    logic [3:0]              lanes;
    logic                    wp_low;
    logic                    pause_low;
    logic                    reset_low;
    logic [7:0]              rx_sh;
    logic [3:0]              rx_cnt;
    logic [7:0]              tx_src;
    logic [3:0]              tx_cnt;

    // ************************************************************
    // width decoding
    // ************************************************************
    function automatic logic [3:0] width_lanes(sfpf_width_e w);
        unique case (w)
            SFPF_W1: width_lanes = SFPF_LANES_1;
            SFPF_W2: width_lanes = SFPF_LANES_2;
            SFPF_W4: width_lanes = SFPF_LANES_4;
            default: width_lanes = SFPF_LANES_1;
        endcase
    endfunction : width_lanes

    function automatic logic [3:0] width_oe(sfpf_width_e w);
        unique case (w)
            SFPF_W1: width_oe = SFPF_OE_1;
            SFPF_W2: width_oe = SFPF_OE_2;
            SFPF_W4: width_oe = SFPF_OE_4;
            default: width_oe = SFPF_OE_1;
        endcase
    endfunction : width_oe

    // ************************************************************
    // pin synchronisers
    // ************************************************************
    sfpf_sync #(
        .W    (SFPF_SYNC_W),
        .INIT (SFPF_SYNC_INIT)
    ) u_sync (
        .clk_sys (clk_sys),
        .rstn    (rstn),
        .din     (pin_in),
        .lvl     (s_lvl),
        .rise    (s_rise),
        .fall    (s_fall)
    );

    assign cs_n     = s_lvl[SFPF_POS_CS];
    assign sck_rise = s_rise[SFPF_POS_SCK];
    assign sck_fall = s_fall[SFPF_POS_SCK];
    assign dl       = s_lvl[SFPF_POS_DL +: 4];
    assign lanes    = width_lanes(xfer_width);

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        next_st           = st;
        next_st.rx_valid  = 1'b0;
        next_st.tx_taken  = 1'b0;
        next_st.sr_reject = 1'b0;
        rx_sh             = st.rx_sh;
        rx_cnt            = st.rx_cnt;
        tx_src            = st.tx_sh;
        tx_cnt            = st.tx_cnt;
        wp_low    = ~st.stat.quad_io_enable & ~dl[2];
        pause_low = ~st.stat.quad_io_enable & ~pause_or_reset_select
                    & ~dl[3];
        reset_low = ~st.stat.quad_io_enable & pause_or_reset_select
                    & ~dl[3];
        next_st.hw_reset = reset_low;

        unique case (st.ls)
            LS_OFF: begin
                if (cs_n) begin
                    next_st.ls = LS_IDLE;
                end
            end
            LS_IDLE: begin
                if (!cs_n) begin
                    next_st.ls     = LS_ACTIVE;
                    next_st.rx_cnt = '0;
                    next_st.tx_cnt = '0;
                end
            end
            LS_ACTIVE: begin
                if (cs_n) begin
                    next_st.ls = LS_IDLE;
                end else if (pause_low) begin
                    next_st.ls = LS_PAUSE;
                end else begin
                    // capture on rise in modes 0 and 3
                    if (sck_rise) begin
                        unique case (xfer_width)
                            SFPF_W1: rx_sh = {st.rx_sh[6:0], dl[0]};
                            SFPF_W2: rx_sh = {st.rx_sh[5:0], dl[1:0]};
                            SFPF_W4: rx_sh = {st.rx_sh[3:0], dl};
                            default: rx_sh = st.rx_sh;
                        endcase
                        rx_cnt = st.rx_cnt + lanes;
                        if (rx_cnt == SFPF_BYTE_BITS) begin
                            next_st.rx_byte  = rx_sh;
                            next_st.rx_valid = 1'b1;
                            rx_cnt           = '0;
                        end
                        next_st.rx_sh  = rx_sh;
                        next_st.rx_cnt = rx_cnt;
                    end
                    if (sck_fall && drive_en) begin
                        if (st.tx_cnt == '0) begin
                            tx_src           = tx_byte;
                            next_st.tx_taken = 1'b1;
                        end
                        unique case (xfer_width)
                            SFPF_W1: begin
                                next_st.dout[1] = tx_src[7];
                                next_st.tx_sh   = {tx_src[6:0], 1'b0};
                            end
                            SFPF_W2: begin
                                next_st.dout[1:0] = tx_src[7:6];
                                next_st.tx_sh     = {tx_src[5:0], 2'b00};
                            end
                            SFPF_W4: begin
                                next_st.dout  = tx_src[7:4];
                                next_st.tx_sh = {tx_src[3:0], 4'h0};
                            end
                            default: next_st.tx_sh = tx_src;
                        endcase
                        tx_cnt = st.tx_cnt + lanes;
                        if (tx_cnt == SFPF_BYTE_BITS) begin
                            tx_cnt = '0;
                        end
                        next_st.tx_cnt = tx_cnt;
                    end
                end
            end
            LS_PAUSE: begin
                if (cs_n) begin
                    next_st.ls = LS_IDLE;
                end else if (!pause_low) begin
                    next_st.ls = LS_ACTIVE;
                end
            end
        endcase

        // reset function of line 3 aborts the frame
        if (reset_low) begin
            next_st.ls     = LS_OFF;
            next_st.rx_cnt = '0;
            next_st.tx_cnt = '0;
        end

        if (next_st.ls == LS_ACTIVE && drive_en) begin
            next_st.doe = width_oe(xfer_width);
        end else begin
            next_st.doe = '0;
        end

        if (sr_wr) begin
            if (st.stat.status_write_disable && wp_low) begin
                next_st.sr_reject = 1'b1;
            end else begin
                next_st.stat = sr_wdata;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            st <= ST_RST;
        end else begin
            st <= next_st;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign pin_out    = '{data_line_out: st.dout, data_line_oe: st.doe};
    assign tx_taken   = st.tx_taken;
    assign rx_byte    = st.rx_byte;
    assign rx_valid   = st.rx_valid;
    assign sr_bits    = st.stat;
    assign sr_reject  = st.sr_reject;
    assign link_state = st.ls;
    assign standby    = (st.ls == LS_OFF) || (st.ls == LS_IDLE);
    assign paused     = (st.ls == LS_PAUSE);
    assign hw_reset   = st.hw_reset;

    // ************************************************************
    // assertions
    // ************************************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    cs_hiz_a: assert property (cs_n |=> pin_out.data_line_oe == 4'h0)
        else $error("output enabled while deselected");
    standby_a: assert property (
        st.ls == LS_ACTIVE && cs_n && !reset_low |=> standby && !paused)
        else $error("deselect did not enter standby");
    select_a: assert property (
        st.ls == LS_IDLE && !cs_n && !reset_low
        |=> st.ls == LS_ACTIVE && !standby)
        else $error("select did not leave standby");
    arm_a: assert property (
        st.ls == LS_OFF && !cs_n |=> st.ls == LS_OFF && !rx_valid)
        else $error("frame accepted before select transition");
    ignore_a: assert property (cs_n |=> !rx_valid ##1 !rx_valid)
        else $error("byte captured while deselected");
    rx_byte_a: assert property (
        st.ls == LS_ACTIVE && !cs_n && !pause_low && !reset_low && sck_rise
        && xfer_width == SFPF_W1 && st.rx_cnt == 4'h7
        |=> rx_valid && rx_byte == {$past(st.rx_sh[6:0]), $past(dl[0])})
        else $error("single line byte capture wrong");
    tx_fall_a: assert property (
        st.ls == LS_ACTIVE && !cs_n && !pause_low && !reset_low && sck_fall
        && drive_en && xfer_width == SFPF_W1 && st.tx_cnt == 4'h0
        |=> tx_taken && pin_out.data_line_out[1] == $past(tx_byte[7])
            && pin_out.data_line_oe == 4'h2)
        else $error("single line output bit wrong");
    quad_pins_a: assert property (
        pin_out.data_line_oe[3] |-> $past(xfer_width) == SFPF_W4)
        else $error("line 3 driven outside quad width");
    wp_lock_a: assert property (
        sr_wr && st.stat.status_write_disable && wp_low
        |=> sr_reject && sr_bits == $past(sr_bits))
        else $error("protected status write not rejected");
    sr_free_a: assert property (
        sr_wr && !st.stat.status_write_disable
        |=> !sr_reject && sr_bits == $past(sr_wdata))
        else $error("unprotected status write lost");
    qe_wp_a: assert property (
        sr_wr && st.stat.quad_io_enable |=> !sr_reject)
        else $error("write protect active with quad enable");
    reset_pin_a: assert property (
        reset_low |=> hw_reset && st.ls == LS_OFF)
        else $error("line 3 reset not taken");
    pause_a: assert property (
        st.ls == LS_PAUSE && pause_low && !cs_n && !reset_low
        |=> pin_out.data_line_oe == 4'h0 && $stable(st.rx_cnt)
            && $stable(st.tx_cnt) && !rx_valid)
        else $error("pause did not freeze the link");

    byte_in_c:  cover property (rx_valid);
    byte_out_c: cover property (tx_taken && xfer_width == SFPF_W4);
    pause_c:    cover property (st.ls == LS_ACTIVE ##1 st.ls == LS_PAUSE);
    reject_c:   cover property (sr_reject);

endmodule : sfpf_front

/* sim/sfpf_host_model.sv */
// Purpose : host side model driving select, clock and data lines
// Assumes : bench calls the tasks; sck half period is 4 clk_sys
// Notes   : clock runs only inside shift, frame just parks it; released lanes float
`timescale 1ns/10ps
module sfpf_host_model
    import sfpf_pkg::*;
(
    input  wire logic       clk_sys,
    input  wire logic [3:0] line,
    output logic            cs_n,
    output logic            sck,
    output logic      [3:0] host_val,
    output logic      [3:0] host_oe
);
    logic wp_lvl;
    logic pause_lvl;

    // ************************************************************
    // pin control
    // ************************************************************
    // select held low from power-up, no edge yet
    initial begin
        cs_n      = 1'b0;
        sck       = 1'b0;
        wp_lvl    = 1'b1;
        pause_lvl = 1'b1;
        host_val  = 4'hC;
        host_oe   = 4'hC;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #5;
    endtask : tick

    task automatic level(input logic wp, input logic pz);
        wp_lvl        = wp;
        pause_lvl     = pz;
        host_val[3:2] = {pz, wp};
    endtask : level

    // clock parked at its idle level before select moves
    task automatic frame(input logic sel, input logic idle);
        sck = idle;
        tick(4);
        cs_n = ~sel;
        tick(6);
    endtask : frame

    // msb first, lanes set on fall, sampled on rise
    task automatic shift(input int nl, input int k, input logic wr,
                         input logic [7:0] din, input logic idle,
                         output logic [7:0] dout);
        logic [7:0] sr;
        sr   = din;
        dout = 8'h00;
        for (int i = 0; i < k; i++) begin
            sck = 1'b0;
            for (int b = 0; b < nl; b++) begin
                host_val[b] = sr[8 - nl + b];
                host_oe[b]  = wr;
            end
            sr = sr << nl;
            tick(4);
            for (int b = nl - 1; b >= 0; b--) begin
                dout = {dout[6:0], (nl == 1) ? line[1] : line[b]};
            end
            sck = 1'b1;
            tick(4);
        end
        sck           = idle;
        host_val[3:2] = {pause_lvl, wp_lvl};
        host_oe       = 4'hC;
    endtask : shift
endmodule : sfpf_host_model

/* sim/test_serial_flash_pin_frontend.sv */
// Purpose : self-checking bench of the serial flash pin front end
// Assumes : host model drives the pins, sck period 800 ns
// Notes   : undriven lanes toggle every cycle
`timescale 1ns/10ps
module test_serial_flash_pin_frontend;
    import sfpf_pkg::*;
    logic          clk_sys    = 1'b0;
    logic          rstn       = 1'b0;
    sfpf_pin_in_s  pin_in;
    sfpf_pin_out_s pin_out;
    sfpf_width_e   xfer_width = SFPF_W1;
    logic          drive_en   = 1'b0;
    logic [7:0]    tx_byte    = 8'h00;
    logic          sr_wr      = 1'b0;
    sfpf_stat_s    sr_wdata   = SFPF_STAT_RST;
    logic          pause_or_reset_select = 1'b0;
    sfpf_stat_s    sr_bits;
    sfpf_link_e    link_state;
    logic [7:0]    rx_byte;
    logic          tx_taken, rx_valid, sr_reject, standby, paused, hw_reset;
    logic          cs_n, sck;
    logic          flt = 1'b0;
    logic [3:0]    host_val, host_oe, line;
    logic [7:0]    got;
    int            miscompares = 0;
    int            n_compared  = 0;
    int            n_rx = 0, n_rej = 0, n_tx = 0, cycles = 0;

    // ************************************************************
    // clock, wires, event counters
    // ************************************************************
    always #50 clk_sys = ~clk_sys;

    for (genvar i = 0; i < 4; i++) begin : g_wire
        assign line[i] = (pin_out.data_line_oe[i] === 1'b1) ?
                         pin_out.data_line_out[i] :
                         (host_oe[i] ? host_val[i] : flt);
    end
    assign pin_in = '{data_line_in: line, chip_select_n: cs_n, sck: sck};

    always @(posedge clk_sys) begin
        flt <= ~flt;
        cycles++;
        if (rx_valid === 1'b1) n_rx++;
        if (tx_taken === 1'b1) n_tx++;
        if (sr_reject === 1'b1) n_rej++;
        if (cycles == 20000) begin
            miscompares++;
            finish_test();
        end
    end

    sfpf_front sfpf_front_inst (
        .clk_sys, .rstn, .pin_in, .pin_out, .xfer_width, .drive_en,
        .tx_byte, .tx_taken, .rx_byte, .rx_valid, .sr_wr, .sr_wdata,
        .sr_bits, .sr_reject, .pause_or_reset_select, .link_state,
        .standby, .paused, .hw_reset
    );

    sfpf_host_model sfpf_host_model_inst (
        .clk_sys, .line, .cs_n, .sck, .host_val, .host_oe
    );

    // ************************************************************
    // helpers
    // ************************************************************
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #5;
    endtask : tick

    task automatic shift(input int nl, input int k, input logic wr,
                         input logic [7:0] d, input logic idle);
        sfpf_host_model_inst.shift(nl, k, wr, d, idle, got);
    endtask : shift

    task automatic frame(input logic sel, input logic idle);
        sfpf_host_model_inst.frame(sel, idle);
    endtask : frame

    task automatic level(input logic wp, input logic pz);
        sfpf_host_model_inst.level(wp, pz);
    endtask : level

    task automatic sr_put(input logic [5:0] d);
        sr_wdata = d;
        sr_wr    = 1'b1;
        tick(1);
        sr_wr    = 1'b0;
        tick(2);
    endtask : sr_put

    task automatic check_bit(input logic g, input logic e, input string m);
        n_compared++;
        if (g !== e) begin
            miscompares++;
            $display("wrong value at %0t: %s got %b exp %b", $time, m, g, e);
        end
    endtask : check_bit

    task automatic check_byte(input logic [7:0] g, input logic [7:0] e,
                              input string m);
        n_compared++;
        if (g !== e) begin
            miscompares++;
            $display("wrong value at %0t: %s got %h exp %h", $time, m, g, e);
        end
    endtask : check_byte

    task automatic finish_test();
        $display("compared %0d, wrong %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : finish_test

    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic t_power_up();
        int r;
        r = n_rx;
        shift(1, 8, 1'b1, 8'h3C, 1'b0);
        tick(4);
        check_byte(8'(n_rx - r), 8'h00, "rx before first select");
        check_bit(standby, 1'b1, "standby at power-up");
        frame(1'b0, 1'b0);
        check_byte(8'(link_state), 8'(LS_IDLE), "idle state");
        check_byte(8'(pin_out.data_line_oe), 8'h00, "oe idle");
        shift(1, 8, 1'b1, 8'h5A, 1'b0);
        tick(4);
        check_byte(8'(n_rx - r), 8'h00, "rx deselected");
        $display("test power_up done");
    endtask : t_power_up

    task automatic t_write();
        int r;
        r = n_rx;
        frame(1'b1, 1'b0);
        check_bit(standby, 1'b0, "standby when selected");
        shift(1, 8, 1'b1, 8'hA5, 1'b0);
        tick(4);
        check_byte(8'(n_rx - r), 8'h01, "single rx count");
        check_byte(rx_byte, 8'hA5, "single rx");
        frame(1'b0, 1'b0);
        $display("test write done");
    endtask : t_write

    task automatic t_status();
        logic [5:0] d [6] = '{6'h25, 6'h2A, 6'h33, 6'h36, 6'h14, 6'h19};
        logic       w [6] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
        sfpf_stat_s e;
        logic       rej;
        int         r;
        e = SFPF_STAT_RST;
        for (int i = 0; i < 6; i++) begin
            level(w[i], 1'b1);
            tick(6);
            rej = e.status_write_disable & ~e.quad_io_enable & ~w[i];
            r   = n_rej;
            sr_put(d[i]);
            if (!rej) e = d[i];
            check_byte(8'(n_rej - r), 8'(rej), "reject");
            check_byte(8'(sr_bits), 8'(e), "protect bits");
        end
        level(1'b1, 1'b1);
        $display("test status done");
    endtask : t_status

    task automatic t_widths();
        sfpf_width_e wd [3] = '{SFPF_W1, SFPF_W2, SFPF_W4};
        logic [3:0]  oe [3] = '{SFPF_OE_1, SFPF_OE_2, SFPF_OE_4};
        int          nl;
        int          r;
        int          t;
        for (int i = 0; i < 3; i++) begin
            nl         = 1 << i;
            xfer_width = wd[i];
            r          = n_rx;
            frame(1'b1, 1'b0);
            shift(nl, 8 / nl, 1'b1, 8'hC3 ^ 8'(i), 1'b0);
            tick(4);
            check_byte(rx_byte, 8'hC3 ^ 8'(i), "lane rx");
            check_byte(8'(n_rx - r), 8'h01, "lane rx count");
            frame(1'b0, 1'b0);
            tx_byte  = 8'h96 ^ 8'(i);
            drive_en = 1'b1;
            frame(1'b1, 1'b1);
            t = n_tx;
            shift(nl, 8 / nl, 1'b0, 8'h00, 1'b1);
            check_byte(got, 8'h96 ^ 8'(i), "lane tx");
            check_byte(8'(n_tx - t), 8'h01, "tx loads");
            check_byte(8'(pin_out.data_line_oe), 8'(oe[i]), "oe");
            frame(1'b0, 1'b1);
            check_byte(8'(pin_out.data_line_oe), 8'h00, "oe off");
            drive_en = 1'b0;
        end
        $display("test widths done");
    endtask : t_widths

    task automatic t_pause();
        int r;
        sr_put(6'h00);
        xfer_width = SFPF_W1;
        r = n_rx;
        frame(1'b1, 1'b0);
        shift(1, 4, 1'b1, 8'hB0, 1'b0);
        drive_en = 1'b1;
        level(1'b1, 1'b0);
        tick(6);
        check_bit(paused, 1'b1, "paused");
        check_byte(8'(pin_out.data_line_oe), 8'h00, "oe paused");
        shift(1, 4, 1'b1, 8'hF0, 1'b0);
        level(1'b1, 1'b1);
        tick(6);
        drive_en = 1'b0;
        shift(1, 4, 1'b1, 8'h70, 1'b0);
        tick(4);
        check_byte(rx_byte, 8'hB7, "byte across pause");
        check_byte(8'(n_rx - r), 8'h01, "one byte");
        frame(1'b0, 1'b0);
        $display("test pause done");
    endtask : t_pause

    task automatic t_hw_reset();
        pause_or_reset_select = 1'b1;
        frame(1'b1, 1'b0);
        level(1'b1, 1'b0);
        tick(6);
        check_bit(hw_reset, 1'b1, "line 3 reset");
        check_byte(8'(link_state), 8'(LS_OFF), "reset state");
        level(1'b1, 1'b1);
        pause_or_reset_select = 1'b0;
        frame(1'b0, 1'b0);
        frame(1'b1, 1'b0);
        shift(1, 8, 1'b1, 8'h4E, 1'b0);
        tick(4);
        check_byte(rx_byte, 8'h4E, "rx after reset");
        frame(1'b0, 1'b0);
        $display("test hw_reset done");
    endtask : t_hw_reset

    initial begin
        tick(5);
        rstn = 1'b1;
        tick(8);
        t_power_up();
        t_write();
        t_status();
        t_widths();
        t_pause();
        t_hw_reset();
        finish_test();
    end
endmodule : test_serial_flash_pin_frontend
